// >>> common/adc_port_consts.svh
`ifndef ADC_PORT_CONSTS_SVH
`define ADC_PORT_CONSTS_SVH
`define RES_WIDTH 16
`define CFG_WIDTH 4
`define NUM_CHAN 8
`define CFG_RESET 4'h0
`define CFG_MODE_BIT 0
`define CONV_TIME_NS 3000
`define CLK_PERIOD_NS 4
`define CONV_CYCLES ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FIFO_DEPTH 8
`endif

// >>> common/adc_port_pkg.sv
package adc_port_pkg;
	typedef struct packed {
		logic [2:0] chan;
		logic [15:0] data;
	} result_s;
	typedef enum logic [1:0] {
		ST_TRACK,
		ST_HOLD,
		ST_CONVERT,
		ST_SLEEP
	} conv_state_e;
endpackage

// >>> design/result_fifo.sv
`timescale 1ns/1ns
module result_fifo #(
	parameter int WIDTH = 19,
	parameter int DEPTH = 8
) (
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire logic flush_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wr_ff;
	logic [AW-1:0] rd_ff;
	logic [AW:0] cnt_ff;
	logic push;
	logic pop;

	assign in_ready_o = (cnt_ff != (AW+1)'(DEPTH));
	assign out_valid_o = (cnt_ff != '0);
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	assign out_data_o = mem_ff[rd_ff];

	always_ff @(posedge sys_clk_i) begin
		if (push) begin
			mem_ff[wr_ff] <= in_data_i;
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wr_ff <= '0;
			rd_ff <= '0;
			cnt_ff <= '0;
		end else if (flush_i) begin
			wr_ff <= '0;
			rd_ff <= '0;
			cnt_ff <= '0;
		end else begin
			if (push) begin
				wr_ff <= (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
			end
			if (pop) begin
				rd_ff <= (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
			end
			cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// Count past depth would mean a push slipped through while full
	fill_bound_a: assert property (@(posedge sys_clk_i)
		disable iff (!resetn_i) cnt_ff <= (AW+1)'(DEPTH))
		else $error("fifo count above depth");
endmodule

// >>> design/adc_host_port.sv
`timescale 1ns/1ns
`include "adc_port_consts.svh"
module adc_host_port
	import adc_port_pkg::*;
#(
	parameter int NUM_CHAN = `NUM_CHAN,
	parameter int CONV_CYCLES = `CONV_CYCLES
) (
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire logic sample_end_trigger_i,
	input wire logic sleep_in_i,
	input wire logic cs_n_i,
	input wire logic rd_n_i,
	input wire logic wr_n_i,
	input wire logic [`RES_WIDTH-1:0] bus_i,
	output logic [`RES_WIDTH-1:0] bus_o,
	output logic [`RES_WIDTH-1:0] bus_oe_o,
	output logic eoc_n_o,
	output logic tracking_o,
	output logic low_power_o,
	output logic [`CFG_WIDTH-1:0] cfg_o,
	input wire logic [NUM_CHAN*`RES_WIDTH-1:0] sample_data_i,
	output logic sample_hold_o
);
	localparam int CW = $clog2(CONV_CYCLES + 1);
	localparam int FW = 19;
	conv_state_e state_ff;
	logic [CW-1:0] conv_cnt_ff;
	logic trig_ff;
	logic rd_ff;
	logic wr_ff;
	logic eoc_n_ff;
	logic [`CFG_WIDTH-1:0] cfg_ff;
	logic [2:0] chan_ff;
	logic [`RES_WIDTH-1:0] dout_ff;
	logic [NUM_CHAN*`RES_WIDTH-1:0] held_ff;
	logic trig_rise;
	logic rd_rise;
	logic wr_rise;
	logic conv_start;
	logic conv_done;
	logic fifo_in_valid;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	result_s fifo_in;
	result_s fifo_out;

	assign trig_rise = sample_end_trigger_i && !trig_ff;
	// Strobe edges only count while selected
	assign rd_rise = rd_n_i && !rd_ff && !cs_n_i;
	assign wr_rise = wr_n_i && !wr_ff && !cs_n_i;
	// Sleep request blocks the start so it cannot flush stored results
	assign conv_start = trig_rise && !sleep_in_i && state_ff != ST_SLEEP &&
		state_ff != ST_CONVERT && chan_ff == 3'h0;
	assign conv_done = state_ff == ST_CONVERT &&
		conv_cnt_ff == CW'(CONV_CYCLES - 1);

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			trig_ff <= 1'b0;
			rd_ff <= 1'b1;
			wr_ff <= 1'b1;
		end else begin
			trig_ff <= sample_end_trigger_i;
			rd_ff <= rd_n_i;
			wr_ff <= wr_n_i;
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_ff <= ST_TRACK;
			conv_cnt_ff <= '0;
		end else if (sleep_in_i) begin
			state_ff <= ST_SLEEP;
			conv_cnt_ff <= '0;
		end else begin
			unique case (state_ff)
				ST_SLEEP: state_ff <= ST_TRACK;
				ST_TRACK, ST_HOLD: begin
					if (conv_start) begin
						state_ff <= ST_CONVERT;
						conv_cnt_ff <= '0;
					end else if (!sample_end_trigger_i &&
						!cfg_ff[`CFG_MODE_BIT]) begin
						state_ff <= ST_TRACK;
					end else begin
						state_ff <= ST_HOLD;
					end
				end
				ST_CONVERT: begin
					if (conv_done) begin
						state_ff <= ST_HOLD;
					end else begin
						conv_cnt_ff <= conv_cnt_ff + 1'b1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			held_ff <= '0;
		end else if (conv_start && !sleep_in_i) begin
			held_ff <= sample_data_i;
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			eoc_n_ff <= 1'b1;
		end else if (conv_start && !sleep_in_i) begin
			eoc_n_ff <= 1'b1;
		end else if (conv_done && !sleep_in_i) begin
			eoc_n_ff <= 1'b0;
		end
	end

	// Sleep leaves this register alone by design
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cfg_ff <= `CFG_RESET;
		end else if (wr_rise) begin
			cfg_ff <= bus_i[`CFG_WIDTH-1:0];
		end
	end

	// Results queued one per channel, drained by fetch edges
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			chan_ff <= 3'h0;
		end else if (conv_done && !sleep_in_i) begin
			chan_ff <= 3'h1;
			if (NUM_CHAN == 1) begin
				chan_ff <= 3'h0;
			end
		end else if (chan_ff != 3'h0 && fifo_in_ready) begin
			chan_ff <= (chan_ff == 3'(NUM_CHAN - 1)) ? 3'h0 : chan_ff + 3'h1;
		end
	end

	assign fifo_in_valid = (conv_done && !sleep_in_i) || chan_ff != 3'h0;
	assign fifo_in.chan = (conv_done && !sleep_in_i) ? 3'h0 : chan_ff;
	assign fifo_in.data = held_ff[fifo_in.chan*`RES_WIDTH +: `RES_WIDTH];
	assign fifo_out_ready = rd_rise;

	result_fifo #(
		.WIDTH(FW),
		.DEPTH(`FIFO_DEPTH)
	) u_fifo (
		.sys_clk_i(sys_clk_i),
		.resetn_i(resetn_i),
		.flush_i(conv_start),
		.in_valid_i(fifo_in_valid),
		.in_ready_o(fifo_in_ready),
		.in_data_i(fifo_in),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(fifo_out_ready),
		.out_data_o(fifo_out)
	);

	// Registered copy so the pins never glitch mid-fetch
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			dout_ff <= 16'h0000;
		end else begin
			dout_ff <= fifo_out_valid ? fifo_out.data : 16'h0000;
		end
	end

	assign bus_o = dout_ff;
	assign bus_oe_o = {`RES_WIDTH{!cs_n_i && !rd_n_i && wr_n_i}};
	assign eoc_n_o = eoc_n_ff;
	assign tracking_o = state_ff == ST_TRACK;
	assign low_power_o = state_ff == ST_SLEEP;
	assign cfg_o = cfg_ff;
	assign sample_hold_o = state_ff == ST_CONVERT || state_ff == ST_HOLD;

	eoc_rise_a: assert property (@(posedge sys_clk_i)
		disable iff (!resetn_i) conv_start && !sleep_in_i |=> eoc_n_o)
		else $error("done flag not cleared at start");
	eoc_fall_a: assert property (@(posedge sys_clk_i)
		disable iff (!resetn_i) conv_done && !sleep_in_i |=> !eoc_n_o)
		else $error("done flag not set at end");
	conv_enter_a: assert property (@(posedge sys_clk_i)
		disable iff (!resetn_i)
		conv_start && !sleep_in_i |=> state_ff == ST_CONVERT)
		else $error("trigger edge did not start conversion");
	track_mode_a: assert property (@(posedge sys_clk_i)
		disable iff (!resetn_i)
		state_ff == ST_HOLD && !sample_end_trigger_i && !cfg_ff[0]
		&& !sleep_in_i |=> state_ff == ST_TRACK)
		else $error("not tracking with trigger low");
	sleep_hold_a: assert property (@(posedge sys_clk_i)
		disable iff (!resetn_i) sleep_in_i ##1 sleep_in_i |-> low_power_o)
		else $error("sleep not entered");
	cfg_keep_a: assert property (@(posedge sys_clk_i)
		disable iff (!resetn_i) !wr_rise |=> $stable(cfg_ff))
		else $error("config changed without write");
	cfg_load_a: assert property (@(posedge sys_clk_i)
		disable iff (!resetn_i) wr_rise |=> cfg_ff == $past(bus_i[3:0]))
		else $error("config not loaded on write edge");
	bus_idle_a: assert property (@(posedge sys_clk_i)
		disable iff (!resetn_i) cs_n_i || rd_n_i |-> bus_oe_o == '0)
		else $error("bus driven outside fetch");
	first_chan_a: assert property (@(posedge sys_clk_i)
		disable iff (!resetn_i)
		conv_done && !sleep_in_i |=> fifo_out_valid && fifo_out.chan == 3'h0)
		else $error("first result not channel 0");
	advance_a: assert property (@(posedge sys_clk_i)
		disable iff (!resetn_i)
		rd_rise && fifo_out_valid && fifo_out.chan != 3'(NUM_CHAN - 1)
		##1 fifo_out_valid |-> fifo_out.chan == $past(fifo_out.chan) + 3'h1)
		else $error("fetch did not advance channel");
endmodule

// >>> tb/host_model.sv
`timescale 1ns/1ns
module host_model (
	input wire logic sys_clk_i,
	output logic cs_n_o,
	output logic rd_n_o,
	output logic wr_n_o,
	output logic [15:0] bus_o,
	input wire logic [15:0] dev_bus_i,
	input wire logic [15:0] dev_oe_i
);
	logic [15:0] drv_ff;
	logic [15:0] last_ff;
	logic drv_en_ff;
	initial begin
		cs_n_o = 1'b1;
		rd_n_o = 1'b1;
		wr_n_o = 1'b1;
		drv_en_ff = 1'b0;
		drv_ff = 16'h0000;
		last_ff = 16'h0000;
	end
	// Undriven bits toggle so a stale value never passes
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			bus_o[i] = dev_oe_i[i] ? dev_bus_i[i] :
				drv_en_ff ? drv_ff[i] : ~last_ff[i];
		end
	end
	always @(posedge sys_clk_i) begin
		last_ff <= bus_o;
	end
	task automatic fetch(input logic sel, input int gap,
		output logic [15:0] val, output logic [15:0] oe);
		@(posedge sys_clk_i);
		cs_n_o <= !sel;
		rd_n_o <= 1'b0;
		repeat (gap) @(posedge sys_clk_i);
		val = bus_o;
		oe = dev_oe_i;
		rd_n_o <= 1'b1;
		@(posedge sys_clk_i);
		cs_n_o <= 1'b1;
		@(posedge sys_clk_i);
	endtask
	task automatic load(input logic sel, input logic [15:0] val);
		@(posedge sys_clk_i);
		cs_n_o <= !sel;
		wr_n_o <= 1'b0;
		drv_ff <= val;
		drv_en_ff <= 1'b1;
		@(posedge sys_clk_i);
		wr_n_o <= 1'b1;
		@(posedge sys_clk_i);
		cs_n_o <= 1'b1;
		drv_en_ff <= 1'b0;
	endtask
endmodule

// >>> tb/testbench.sv
`timescale 1ns/1ns
module testbench;
	localparam int CONV = 10;
	logic clk, rst_n, trig, sleep, cs_n, rd_n, wr_n;
	logic eoc_n, trk, lp, hold;
	logic [15:0] bus_w, dev_bus, dev_oe, v, oe;
	logic [3:0] cfg;
	logic [127:0] sd;
	int num_errors = 0;
	int n_tests = 0;
	adc_host_port #(.NUM_CHAN(8), .CONV_CYCLES(CONV)) i_dut (
		.sys_clk_i(clk), .resetn_i(rst_n), .sample_end_trigger_i(trig),
		.sleep_in_i(sleep), .cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n),
		.bus_i(bus_w), .bus_o(dev_bus), .bus_oe_o(dev_oe),
		.eoc_n_o(eoc_n), .tracking_o(trk), .low_power_o(lp),
		.cfg_o(cfg), .sample_data_i(sd), .sample_hold_o(hold));
	host_model i_host (.sys_clk_i(clk), .cs_n_o(cs_n), .rd_n_o(rd_n),
		.wr_n_o(wr_n), .bus_o(bus_w), .dev_bus_i(dev_bus),
		.dev_oe_i(dev_oe));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Bounded wait: a hang counts as a mismatch
	task automatic wait_lp(input logic lvl);
		int n;
		n = 0;
		while (lp !== lvl) begin
			@(posedge clk);
			#1;
			if (++n > 50) begin
				num_errors++;
				report_and_stop();
			end
		end
	endtask
	task automatic t_cfg();
		i_host.load(1'b1, 16'hfff5);
		@(posedge clk);
		#1;
		check(16'(cfg), 16'h0005);
		check(16'(trk), 16'h0000);
		i_host.load(1'b0, 16'h000a);
		@(posedge clk);
		#1;
		check(16'(cfg), 16'h0005);
		i_host.load(1'b1, 16'h000a);
		@(posedge clk);
		#1;
		check(16'(cfg), 16'h000a);
		check(16'(trk), 16'h0001);
		$display("test cfg done");
	endtask
	task automatic t_conv(input logic [15:0] base);
		int n;
		@(posedge clk);
		for (int k = 0; k < 8; k++) begin
			sd[16*k +: 16] <= base + 16'(k);
		end
		trig <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
			if (n == 2) begin
				check(16'(eoc_n), 16'h0001);
				check(16'({hold, trk}), 16'h0002);
			end
			if (n > 100) begin
				num_errors++;
				report_and_stop();
			end
		end while (eoc_n !== 1'b0);
		check(16'(n), 16'(CONV + 1));
		@(posedge clk);
		trig <= 1'b0;
		// Queue loads one channel per cycle after done
		repeat (8) @(posedge clk);
		#1;
		check(16'(trk), 16'h0001);
		for (int k = 0; k < 9; k++) begin
			if (k == 3) begin
				i_host.fetch(1'b0, 1, v, oe);
				check(oe, 16'h0000);
			end
			i_host.fetch(1'b1, 1 + k % 3, v, oe);
			check(oe, 16'hffff);
			check(v, k < 8 ? base + 16'(k) : 16'h0000);
		end
		$display("test conversion done");
	endtask
	task automatic t_sleep();
		@(posedge clk);
		sleep <= 1'b1;
		wait_lp(1'b1);
		check(16'(cfg), 16'h000a);
		@(posedge clk);
		trig <= 1'b1;
		repeat (CONV + 4) @(posedge clk);
		#1;
		check(16'({lp, eoc_n}), 16'h0002);
		@(posedge clk);
		trig <= 1'b0;
		sleep <= 1'b0;
		wait_lp(1'b0);
		check(16'(cfg), 16'h000a);
		$display("test sleep done");
	endtask
	initial begin
		rst_n = 1'b0;
		trig = 1'b0;
		sleep = 1'b0;
		sd = '0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1;
		check(16'({eoc_n, trk, cfg}), 16'h0030);
		check(dev_oe, 16'h0000);
		t_cfg();
		t_conv(16'h1230);
		t_conv(16'hab00);
		t_sleep();
		report_and_stop();
	end
endmodule
